// File: src/tftst_pkg.sv
// Package with the register map, field layouts and state types of the TFT panel timing generator.
package tftst_pkg;

  // -------------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------------
  localparam int unsigned TFTST_AW        = 8;
  localparam logic [7:0]  TFTST_OFF_CTRL  = 8'h00;
  localparam logic [7:0]  TFTST_OFF_DIV   = 8'h04;
  localparam logic [7:0]  TFTST_OFF_EDGE  = 8'h08;
  localparam logic [7:0]  TFTST_OFF_HOR   = 8'h0C;
  localparam logic [7:0]  TFTST_OFF_HDLY  = 8'h10;
  localparam logic [7:0]  TFTST_OFF_VER   = 8'h14;
  localparam logic [7:0]  TFTST_OFF_POS   = 8'h18;
  localparam logic [7:0]  TFTST_OFF_SIZE  = 8'h1C;
  localparam logic [7:0]  TFTST_OFF_REFL1 = 8'h20;
  localparam logic [7:0]  TFTST_OFF_REFL2 = 8'h24;
  localparam logic [7:0]  TFTST_OFF_REV   = 8'h28;
  localparam logic [7:0]  TFTST_OFF_STAT  = 8'h2C;

  // -------------------------------------------------------------------------
  // Field positions and widths
  // -------------------------------------------------------------------------
  localparam int unsigned TFTST_CW        = 12;
  localparam int unsigned TFTST_HI_LSB    = 12;
  localparam int unsigned TFTST_B8_LSB    = 8;
  localparam int unsigned TFTST_B16_LSB   = 16;
  localparam int unsigned TFTST_CTL_EN    = 0;
  localparam int unsigned TFTST_CTL_CINV  = 1;
  localparam int unsigned TFTST_CTL_HLOW  = 2;
  localparam int unsigned TFTST_CTL_VLOW  = 3;
  localparam int unsigned TFTST_CTL_DLOW  = 4;
  localparam int unsigned TFTST_CTL_VLINE = 5;
  localparam int unsigned TFTST_CTL_REFL  = 6;
  localparam int unsigned TFTST_STAT_VS   = 24;
  localparam int unsigned TFTST_DW        = 18;

  // -------------------------------------------------------------------------
  // Reset values and phase ceiling
  // -------------------------------------------------------------------------
  localparam logic [7:0]  TFTST_RST_FAST  = 8'h01;
  localparam logic [7:0]  TFTST_RST_PER   = 8'h02;
  localparam logic [7:0]  TFTST_RST_FALL  = 8'h01;
  localparam logic [7:0]  TFTST_RST_RISE  = 8'h00;
  localparam logic [11:0] TFTST_RST_ZERO  = 12'h000;
  localparam logic [9:0]  TFTST_ACC_ZERO  = 10'h000;
  localparam logic [15:0] TFTST_PH_MAX    = 16'hFF00;

  typedef struct packed {
    logic [6:0]  ctrl;
    logic [7:0]  fast_set;
    logic [7:0]  per_set;
    logic [7:0]  div_cnt;
    logic [7:0]  fall_pt;
    logic [7:0]  rise_pt;
    logic [11:0] scr_w;
    logic [11:0] hs_w;
    logic [11:0] hs_dly;
    logic [11:0] scr_h;
    logic [11:0] vs_w;
    logic [11:0] x_start;
    logic [11:0] y_start;
    logic [11:0] act_w;
    logic [11:0] act_h;
    logic [11:0] gate_rise;
    logic [11:0] gate_fall;
    logic [11:0] save_fall;
    logic [11:0] save_rise;
    logic [11:0] rev_dly;
  } tftst_cfg_t;

  typedef struct packed {
    logic                clk_o;
    logic                hs_o;
    logic                vs_o;
    logic                dv_o;
    logic                spl_o;
    logic                cls_o;
    logic                ps_o;
    logic                rev_o;
    logic [TFTST_DW-1:0] data_o;
  } tftst_pins_t;

endpackage : tftst_pkg

// File: src/tftst_timing.sv
// TFT panel timing generator with fractional interface clock, pixel divider and sync counters.
`timescale 1ns/1ps
module tftst_timing
  import tftst_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  input  wire logic [TFTST_AW-1:0] i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  input  wire logic [TFTST_DW-1:0] i_pixel_data,
  output logic      [31:0]         o_rdata,
  output logic                     o_panel_pixel_clock_out,
  output logic                     o_line_sync_out,
  output logic                     o_frame_sync_out,
  output logic                     o_pixel_valid_out,
  output logic                     o_row_start_pulse,
  output logic                     o_gate_clock_pulse,
  output logic                     o_power_save_pulse,
  output logic                     o_polarity_reverse,
  output logic      [TFTST_DW-1:0] o_pixel_data
);

  typedef struct packed {
    tftst_cfg_t          cfg;
    logic [31:0]         rdata;
    logic [9:0]          iacc;
    logic [7:0]          pdiv;
    logic [15:0]         phase;
    logic [11:0]         hcnt;
    logic [11:0]         vcnt;
    logic                rev;
    tftst_pins_t         pins;
  } tftst_state_t;

  tftst_state_t s_q;
  tftst_state_t s_d;

  // -------------------------------------------------------------------------
  // Combinational helpers
  // -------------------------------------------------------------------------
  logic        en;
  logic        itick;
  logic        ptick;
  logic [9:0]  iacc_sum;
  logic [12:0] hs_end;
  logic [12:0] vs_end;
  logic [12:0] x_end;
  logic [12:0] y_end;
  logic [12:0] h_ext;
  logic [12:0] v_ext;
  logic        line_act;
  logic        frame_act;
  logic        win;
  logic        clk_raw;
  logic        refl;

  assign en       = s_q.cfg.ctrl[TFTST_CTL_EN];
  assign refl     = s_q.cfg.ctrl[TFTST_CTL_REFL];
  assign iacc_sum = s_q.iacc + {2'b00, s_q.cfg.fast_set};
  // Fractional accumulator: whole counts alternate so the mean period is exact.
  assign itick    = en && (iacc_sum >= {2'b00, s_q.cfg.per_set});
  assign ptick    = itick && (s_q.pdiv == s_q.cfg.div_cnt);
  assign h_ext    = {1'b0, s_q.hcnt};
  assign v_ext    = {1'b0, s_q.vcnt};
  assign hs_end   = {1'b0, s_q.cfg.hs_dly} + {1'b0, s_q.cfg.hs_w};
  assign vs_end   = {1'b0, s_q.cfg.hs_dly} + {1'b0, s_q.cfg.vs_w};
  assign x_end    = {1'b0, s_q.cfg.x_start} + {1'b0, s_q.cfg.act_w};
  assign y_end    = {1'b0, s_q.cfg.y_start} + {1'b0, s_q.cfg.act_h};

  // Line sync spans width plus one pixels starting at the sync delay.
  assign line_act = (s_q.hcnt >= s_q.cfg.hs_dly) && (h_ext <= hs_end);

  // Frame sync counted in pixels of the first line, or in whole lines.
  always_comb begin
    if (s_q.cfg.ctrl[TFTST_CTL_VLINE]) begin
      frame_act = (s_q.vcnt <= s_q.cfg.vs_w);
    end else begin
      frame_act = (s_q.vcnt == TFTST_RST_ZERO) && (s_q.hcnt >= s_q.cfg.hs_dly) && (h_ext <= vs_end);
    end
  end

  // Active window: leading blanks are the start positions, trailing blanks the rest.
  assign win = (s_q.hcnt >= s_q.cfg.x_start) && (h_ext <= x_end) &&
               (s_q.vcnt >= s_q.cfg.y_start) && (v_ext <= y_end);

  // Clock falls at the fall point and rises again at the rise point, or at the next pixel start if the rise point is not above the fall point.
  assign clk_raw = !((s_q.phase >= {8'h00, s_q.cfg.fall_pt}) &&
                     ((s_q.cfg.rise_pt <= s_q.cfg.fall_pt) || (s_q.phase < {8'h00, s_q.cfg.rise_pt})));

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Register writes.
    if (i_wr) begin
      case (i_addr)
        TFTST_OFF_CTRL: begin
          s_d.cfg.ctrl = i_wdata[6:0];
        end
        TFTST_OFF_DIV: begin
          s_d.cfg.fast_set = i_wdata[7:0];
          s_d.cfg.per_set  = i_wdata[TFTST_B8_LSB +: 8];
          s_d.cfg.div_cnt  = i_wdata[TFTST_B16_LSB +: 8];
        end
        TFTST_OFF_EDGE: begin
          s_d.cfg.fall_pt = i_wdata[7:0];
          s_d.cfg.rise_pt = i_wdata[TFTST_B8_LSB +: 8];
        end
        TFTST_OFF_HOR: begin
          s_d.cfg.scr_w = i_wdata[TFTST_CW-1:0];
          s_d.cfg.hs_w  = i_wdata[TFTST_HI_LSB +: TFTST_CW];
        end
        TFTST_OFF_HDLY: begin
          s_d.cfg.hs_dly = i_wdata[TFTST_CW-1:0];
        end
        TFTST_OFF_VER: begin
          s_d.cfg.scr_h = i_wdata[TFTST_CW-1:0];
          s_d.cfg.vs_w  = i_wdata[TFTST_HI_LSB +: TFTST_CW];
        end
        TFTST_OFF_POS: begin
          s_d.cfg.x_start = i_wdata[TFTST_CW-1:0];
          s_d.cfg.y_start = i_wdata[TFTST_HI_LSB +: TFTST_CW];
        end
        TFTST_OFF_SIZE: begin
          s_d.cfg.act_w = i_wdata[TFTST_CW-1:0];
          s_d.cfg.act_h = i_wdata[TFTST_HI_LSB +: TFTST_CW];
        end
        TFTST_OFF_REFL1: begin
          s_d.cfg.gate_rise = i_wdata[TFTST_CW-1:0];
          s_d.cfg.gate_fall = i_wdata[TFTST_HI_LSB +: TFTST_CW];
        end
        TFTST_OFF_REFL2: begin
          s_d.cfg.save_fall = i_wdata[TFTST_CW-1:0];
          s_d.cfg.save_rise = i_wdata[TFTST_HI_LSB +: TFTST_CW];
        end
        TFTST_OFF_REV: begin
          s_d.cfg.rev_dly = i_wdata[TFTST_CW-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads answer in the following cycle; unmapped words read zero.
    s_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        TFTST_OFF_CTRL:  s_d.rdata = {25'h000_0000, s_q.cfg.ctrl};
        TFTST_OFF_DIV:   s_d.rdata = {8'h00, s_q.cfg.div_cnt, s_q.cfg.per_set, s_q.cfg.fast_set};
        TFTST_OFF_EDGE:  s_d.rdata = {16'h0000, s_q.cfg.rise_pt, s_q.cfg.fall_pt};
        TFTST_OFF_HOR:   s_d.rdata = {8'h00, s_q.cfg.hs_w, s_q.cfg.scr_w};
        TFTST_OFF_HDLY:  s_d.rdata = {20'h0_0000, s_q.cfg.hs_dly};
        TFTST_OFF_VER:   s_d.rdata = {8'h00, s_q.cfg.vs_w, s_q.cfg.scr_h};
        TFTST_OFF_POS:   s_d.rdata = {8'h00, s_q.cfg.y_start, s_q.cfg.x_start};
        TFTST_OFF_SIZE:  s_d.rdata = {8'h00, s_q.cfg.act_h, s_q.cfg.act_w};
        TFTST_OFF_REFL1: s_d.rdata = {8'h00, s_q.cfg.gate_fall, s_q.cfg.gate_rise};
        TFTST_OFF_REFL2: s_d.rdata = {8'h00, s_q.cfg.save_rise, s_q.cfg.save_fall};
        TFTST_OFF_REV:   s_d.rdata = {20'h0_0000, s_q.cfg.rev_dly};
        TFTST_OFF_STAT:  s_d.rdata = {7'h00, frame_act, s_q.vcnt, s_q.hcnt};
        default:         s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Interface clock accumulator and pixel divider.
    if (!en) begin
      s_d.iacc  = TFTST_ACC_ZERO;
      s_d.pdiv  = 8'h00;
      s_d.phase = 16'h0000;
      s_d.hcnt  = TFTST_RST_ZERO;
      s_d.vcnt  = TFTST_RST_ZERO;
      s_d.rev   = 1'b0;
    end else begin
      s_d.iacc = itick ? (iacc_sum - {2'b00, s_q.cfg.per_set}) : iacc_sum;
      if (itick) begin
        s_d.pdiv = ptick ? 8'h00 : (s_q.pdiv + 8'h01);
      end
      if (ptick) begin
        s_d.phase = 16'h0000;
      end else if (s_q.phase < TFTST_PH_MAX) begin
        s_d.phase = s_q.phase + {8'h00, s_q.cfg.fast_set};
      end
      if (ptick) begin
        if (s_q.hcnt >= s_q.cfg.scr_w) begin
          s_d.hcnt = TFTST_RST_ZERO;
          s_d.vcnt = (s_q.vcnt >= s_q.cfg.scr_h) ? TFTST_RST_ZERO : (s_q.vcnt + 12'h001);
        end else begin
          s_d.hcnt = s_q.hcnt + 12'h001;
        end
        if (refl && (s_q.hcnt == s_q.cfg.rev_dly)) begin
          s_d.rev = !s_q.rev;
        end
      end
    end

    // Registered panel pins, with polarity applied to line sync, frame sync and data valid, and to the clock while enabled; a disabled clock is held low.
    s_d.pins.clk_o  = en ? (clk_raw ^ s_q.cfg.ctrl[TFTST_CTL_CINV]) : 1'b0;
    s_d.pins.hs_o   = (en && line_act) ^ s_q.cfg.ctrl[TFTST_CTL_HLOW];
    s_d.pins.vs_o   = (en && frame_act) ^ s_q.cfg.ctrl[TFTST_CTL_VLOW];
    s_d.pins.dv_o   = (en && win) ^ s_q.cfg.ctrl[TFTST_CTL_DLOW];
    s_d.pins.data_o = (en && win) ? i_pixel_data : s_q.pins.data_o;
    s_d.pins.spl_o  = en && refl && ((h_ext + 13'h0001) == {1'b0, s_q.cfg.x_start});
    if (!(en && refl)) begin
      s_d.pins.cls_o = 1'b0;
      s_d.pins.ps_o  = 1'b1;
    end else begin
      if (s_q.hcnt == s_q.cfg.gate_rise) begin
        s_d.pins.cls_o = 1'b1;
      end else if (s_q.hcnt == s_q.cfg.gate_fall) begin
        s_d.pins.cls_o = 1'b0;
      end
      if (s_q.hcnt == s_q.cfg.save_fall) begin
        s_d.pins.ps_o = 1'b0;
      end else if (s_q.hcnt == s_q.cfg.save_rise) begin
        s_d.pins.ps_o = 1'b1;
      end
    end
    s_d.pins.rev_o = s_q.rev;
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q               <= '0;
      s_q.cfg.fast_set  <= TFTST_RST_FAST;
      s_q.cfg.per_set   <= TFTST_RST_PER;
      s_q.cfg.fall_pt   <= TFTST_RST_FALL;
      s_q.cfg.rise_pt   <= TFTST_RST_RISE;
      s_q.pins.ps_o     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata                 = s_q.rdata;
  assign o_panel_pixel_clock_out = s_q.pins.clk_o;
  assign o_line_sync_out         = s_q.pins.hs_o;
  assign o_frame_sync_out        = s_q.pins.vs_o;
  assign o_pixel_valid_out       = s_q.pins.dv_o;
  assign o_row_start_pulse       = s_q.pins.spl_o;
  assign o_gate_clock_pulse      = s_q.pins.cls_o;
  assign o_power_save_pulse      = s_q.pins.ps_o;
  assign o_polarity_reverse      = s_q.pins.rev_o;
  assign o_pixel_data            = s_q.pins.data_o;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_pix_div;
    itick |=> (s_q.pdiv == ($past(ptick) ? 8'h00 : ($past(s_q.pdiv) + 8'h01)));
  endproperty
  a_pix_div: assert property (p_pix_div) else $error("pixel tick off divide count");

  property p_iface_frac;
    (en && (s_q.cfg.per_set > {s_q.cfg.fast_set[6:0], 1'b0}) && $stable(s_q.cfg)) ##0 itick |=> !itick;
  endproperty
  a_iface_frac: assert property (p_iface_frac) else $error("interface ticks too close");

  property p_line_wrap;
    ptick && (s_q.hcnt >= s_q.cfg.scr_w) |=> (s_q.hcnt == TFTST_RST_ZERO);
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line counter did not restart");

  property p_frame_wrap;
    ptick && (s_q.hcnt >= s_q.cfg.scr_w) && (s_q.vcnt >= s_q.cfg.scr_h) |=> (s_q.vcnt == TFTST_RST_ZERO);
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not restart");

  property p_valid_window;
    (o_pixel_valid_out ^ s_q.cfg.ctrl[TFTST_CTL_DLOW]) && $stable(s_q.cfg) |-> $past(win) && $past(en);
  endproperty
  a_valid_window: assert property (p_valid_window) else $error("data ready outside window");

  property p_clk_start;
    en && ptick && $stable(s_q.cfg) |-> ##2 (o_panel_pixel_clock_out == !s_q.cfg.ctrl[TFTST_CTL_CINV]);
  endproperty
  a_clk_start: assert property (p_clk_start) else $error("pixel clock not in idle phase at pixel start");

  property p_hsync_level;
    en && line_act && $stable(s_q.cfg) |=> (o_line_sync_out != s_q.cfg.ctrl[TFTST_CTL_HLOW]);
  endproperty
  a_hsync_level: assert property (p_hsync_level) else $error("line sync not asserted");

  property p_rev_toggle;
    $changed(s_q.rev) && en |-> $past(ptick) && $past(refl) && ($past(s_q.hcnt) == $past(s_q.cfg.rev_dly));
  endproperty
  a_rev_toggle: assert property (p_rev_toggle) else $error("reverse toggled off its delay");

  property p_row_start;
    o_row_start_pulse |-> $past(refl) && (($past(h_ext) + 13'h0001) == {1'b0, $past(s_q.cfg.x_start)});
  endproperty
  a_row_start: assert property (p_row_start) else $error("row start off position");

  property p_vsync_level;
    en && frame_act && $stable(s_q.cfg) |=> (o_frame_sync_out != s_q.cfg.ctrl[TFTST_CTL_VLOW]);
  endproperty
  a_vsync_level: assert property (p_vsync_level) else $error("frame sync not asserted");

  property p_gate_rise;
    en && refl && (s_q.hcnt == s_q.cfg.gate_rise) |=> o_gate_clock_pulse;
  endproperty
  a_gate_rise: assert property (p_gate_rise) else $error("gate clock did not rise at its delay");

  property p_save_fall;
    en && refl && (s_q.hcnt == s_q.cfg.save_fall) |=> !o_power_save_pulse;
  endproperty
  a_save_fall: assert property (p_save_fall) else $error("power save did not fall at its delay");

  property p_data_hold;
    !(en && win) |=> $stable(o_pixel_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("pixel data changed outside window");

endmodule : tftst_timing

// File: verif/tft_panel_sync_timing_tb_top.sv
// Self-checking bench for the TFT panel timing generator with randomised geometry.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tft_panel_sync_timing_tb_top;
  import tftst_pkg::*;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
  logic [17:0] i_pixel_data = 18'h0_0000, o_pixel_data;
  logic o_pclk, o_hs, o_vs, o_dv, o_spl, o_gate, o_save, o_rev;
  logic hlow = 1'b0, vlow = 1'b0, dlow = 1'b0, inv = 1'b0, hs_a, vs_a, dv_a;
  logic hs_p = 1'b0, vs_p = 1'b0, dv_p = 1'b0, ck_p = 1'b0, rv_p = 1'b0, sp_p = 1'b0;
  logic [15:0] lfsr_q = 16'hA9B8;
  int err_total = 0, n_tests = 0, pp = 2, lat, hsv;
  int cyc = 0, hs_t = 0, vs_t = 0, dv_c = 0, dv_o = 0, tg_c = 0, rv_c = 0, sp_c = 0, sp_o = 0;
  int gt_c = 0, sv_c = 0, lidx = 0, dvl = 0, fdv = -1, frames = 0, pd_n = 0, pd_e = 0;
  logic [17:0] pd_q = 18'h0_0000;
  int m_line, m_hsw, m_dv, m_dvo, m_tog, m_rev, m_spw, m_spo, m_gate, m_save, m_frame, m_vsw, m_dvl, m_fdv;
  assign hs_a = o_hs ^ hlow;
  assign vs_a = o_vs ^ vlow;
  assign dv_a = o_dv ^ dlow;
  // ---------------------------------------------------------------------------
  // Design, panel and clock
  // ---------------------------------------------------------------------------
  tftst_timing dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_pixel_data(i_pixel_data), .o_rdata(o_rdata), .o_panel_pixel_clock_out(o_pclk),
    .o_line_sync_out(o_hs), .o_frame_sync_out(o_vs), .o_pixel_valid_out(o_dv), .o_row_start_pulse(o_spl),
    .o_gate_clock_pulse(o_gate), .o_power_save_pulse(o_save), .o_polarity_reverse(o_rev),
    .o_pixel_data(o_pixel_data));
  tftst_panel_model panel (.i_clock(i_clock), .i_pclk(o_pclk), .i_inv(inv), .i_hs(hs_a), .i_vs(vs_a),
    .i_dv(dv_a), .o_lat_line(lat), .o_hs_in_vs(hsv));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic int rnd(input int m);
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return int'(lfsr_q) % m;
  endfunction
  function automatic int ex(input int pixels);
    return pixels * pp;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = frames + n;
    for (int k = 0; k < 20000 && frames < t; k++) @(posedge i_clock);
    `CHK(frames, t)
  endtask
  task final_report;
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock) begin
    i_pixel_data <= {2'b00, lfsr_q ^ 16'(cyc)};
  end
  // ---------------------------------------------------------------------------
  // Line and frame measurement in fast clock cycles
  // ---------------------------------------------------------------------------
  always @(posedge i_clock) begin
    cyc <= cyc + 1; hs_p <= hs_a; vs_p <= vs_a; dv_p <= dv_a; ck_p <= o_pclk; rv_p <= o_rev; sp_p <= o_spl;
    tg_c <= tg_c + int'(o_pclk != ck_p); rv_c <= rv_c + int'(o_rev != rv_p);
    sp_c <= sp_c + int'(o_spl); gt_c <= gt_c + int'(o_gate); sv_c <= sv_c + int'(!o_save);
    if (dv_a) dv_c <= dv_c + 1;
    pd_q <= i_pixel_data;
    if (dv_a) begin pd_n <= pd_n + 1; pd_e <= pd_e + int'(o_pixel_data !== pd_q); end
    if (dv_a && !dv_p) begin dv_o <= cyc - hs_t; if (fdv < 0) fdv <= lidx; end
    if (o_spl && !sp_p) sp_o <= cyc - hs_t;
    if (!hs_a && hs_p) m_hsw <= cyc - hs_t;
    if (!vs_a && vs_p) m_vsw <= cyc - vs_t;
    if (hs_a && !hs_p) begin
      m_line <= cyc - hs_t; hs_t <= cyc; lidx <= lidx + 1;
      m_tog <= tg_c; m_rev <= rv_c; m_spw <= sp_c; m_spo <= sp_o; m_gate <= gt_c; m_save <= sv_c;
      tg_c <= int'(o_pclk != ck_p); rv_c <= int'(o_rev != rv_p);
      sp_c <= int'(o_spl); gt_c <= int'(o_gate); sv_c <= int'(!o_save); dv_c <= 0;
      if (dv_c != 0) begin m_dv <= dv_c; m_dvo <= dv_o; dvl <= dvl + 1; end
    end
    if (vs_a && !vs_p) begin
      m_frame <= cyc - vs_t; vs_t <= cyc; m_dvl <= dvl; dvl <= 0; m_fdv <= fdv; fdv <= -1;
      lidx <= (hs_a && !hs_p) ? 0 : -1; frames <= frames + 1;
    end
  end
  // ---------------------------------------------------------------------------
  // One randomised configuration run
  // ---------------------------------------------------------------------------
  task automatic run_cfg(input int c);
    int sw, hw, hd, sh, vw, xs, ys, aw, ah, dv;
    logic [31:0] d;
    logic [6:0] ctl;
    sw = 21 + 2 * rnd(4); hw = 1 + rnd(3); hd = 1 + rnd(2); sh = 9 + rnd(4);
    vw = (c == 1) ? 1 : hw + 2; xs = hd + hw + 2 + rnd(2); aw = 7 + rnd(4); ys = 2 + rnd(2); ah = 3 + rnd(2);
    dv = rnd(2);
    ctl = (c == 1) ? 7'h7F : 7'h01;
    pp = (c == 1) ? 3 : 3 * (dv + 1);
    wr(TFTST_OFF_CTRL, 32'h0000_0000);
    wr(TFTST_OFF_DIV, (c == 1) ? 32'h0001_0302 : {8'h00, 8'(dv), 16'h0301});
    wr(TFTST_OFF_EDGE, 32'h0000_0001);
    wr(TFTST_OFF_HOR, {8'h00, 12'(hw), 12'(sw)});
    wr(TFTST_OFF_HDLY, 32'(hd));
    wr(TFTST_OFF_VER, {8'h00, 12'(vw), 12'(sh)});
    wr(TFTST_OFF_POS, {8'h00, 12'(ys), 12'(xs)});
    wr(TFTST_OFF_SIZE, {8'h00, 12'(ah), 12'(aw)});
    wr(TFTST_OFF_REFL1, {8'h00, 12'h005, 12'h002});
    wr(TFTST_OFF_REFL2, {8'h00, 12'h009, 12'h003});
    wr(TFTST_OFF_REV, 32'h0000_0004);
    wr(8'h30, 32'hFFFF_FFFF);
    wr(TFTST_OFF_CTRL, {25'h0, ctl});
    @(posedge i_clock);
    @(negedge i_clock);
    hlow = ctl[2]; vlow = ctl[3]; dlow = ctl[4]; inv = ctl[1];
    rd(TFTST_OFF_HOR, d);
    `CHK(d[23:0], {12'(hw), 12'(sw)})
    rd(8'h30, d);
    `CHK(d, 32'h0000_0000)
    rd(TFTST_OFF_CTRL, d);
    `CHK(d[6:0], ctl)
    wait_frames(3);
    `CHK(m_line, ex(sw + 1))
    `CHK(m_hsw, ex(hw + 1))
    `CHK(m_tog, 2 * (sw + 1))
    `CHK(lat, aw + 1)
    `CHK(m_dv, ex(aw + 1))
    `CHK(m_dvo, ex(xs - hd))
    `CHK(m_line - m_dvo - m_dv, ex(sw - xs - aw + hd))
    `CHK(m_frame, (sh + 1) * ex(sw + 1))
    `CHK(m_vsw, (c == 1) ? (vw + 1) * ex(sw + 1) : ex(vw + 1))
    `CHK(m_fdv, ys)
    `CHK(m_dvl, ah + 1)
    `CHK(hsv >= 1, 1'b1)
    `CHK(m_rev, int'(ctl[6]))
    `CHK(m_spw, ctl[6] ? ex(1) : 0)
    if (ctl[6]) `CHK(m_spo, ex(xs - 1 - hd))
    `CHK(m_gate, ctl[6] ? ex(3) : 0)
    `CHK(m_save, ctl[6] ? ex(6) : 0)
    `CHK(pd_e, 0)
    `CHK(pd_n > 0, 1'b1)
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  task automatic reset_check;
    logic [31:0] d;
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    #1 `CHK({o_pclk, o_hs, o_vs, o_dv, o_save, o_rdata}, {5'b00001, 32'h0000_0000})
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(TFTST_OFF_DIV, d);
    `CHK(d, 32'h0000_0201)
    rd(TFTST_OFF_EDGE, d);
    `CHK(d, 32'h0000_0001)
    rd(TFTST_OFF_CTRL, d);
    `CHK(d, 32'h0000_0000)
  endtask
  initial begin
    reset_check();
    run_cfg(0);
    reset_check();
    run_cfg(1);
    final_report();
  end
  initial begin
    #(5 * 80000);
    err_total++;
    final_report();
  end
endmodule // tft_panel_sync_timing_tb_top

// File: verif/tftst_panel_model.sv
// Behavioural panel that latches pixels on its latch edge and keeps line and frame bookkeeping.
`timescale 1ns/1ps
module tftst_panel_model (
  input  wire logic i_clock,
  input  wire logic i_pclk,
  input  wire logic i_inv,
  input  wire logic i_hs,
  input  wire logic i_vs,
  input  wire logic i_dv,
  output int        o_lat_line,
  output int        o_hs_in_vs
);
  logic ck_p = 1'b0;
  logic hs_p = 1'b0;
  logic vs_p = 1'b0;
  int   lat  = 0;
  int   hsv  = 0;
  // ---------------------------------------------------------------------------
  // Pixel latch and sync bookkeeping
  // ---------------------------------------------------------------------------
  always @(posedge i_clock) begin
    ck_p <= i_pclk ^ i_inv;
    hs_p <= i_hs;
    vs_p <= i_vs;
    if (ck_p && !(i_pclk ^ i_inv) && i_dv) begin
      lat <= lat + 1;
    end
    if (i_hs && !hs_p) begin
      lat <= 0;
      if (lat != 0) begin
        o_lat_line <= lat;
      end
    end
    if (!i_hs && hs_p && i_vs) begin
      hsv <= hsv + 1;
    end
    if (i_vs && !vs_p) begin
      hsv <= 0;
    end
    if (!i_vs && vs_p) begin
      o_hs_in_vs <= hsv;
    end
  end
endmodule // tftst_panel_model
